// File: rts_sequencer.sv
// rts_sequencer: reset combiner, power-up timer, oscillator start counter
// assumes async pins are raw; presetn is the analog power-on detector
//
// Local design decisions: the placing of the registers and the APB register port.
`timescale 1ns/10ps
`default_nettype none
module rts_sequencer
  import rts_pkg::*;
#(
  parameter int POWERUP_TIMER_CYC = RTS_POWERUP_TIMER_CYC,
  parameter int OST_CNT = RTS_OST_CNT,
  parameter int FILT_CYC = RTS_FILT_CYC,
  parameter int BOR_CYC = RTS_BOR_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic supply_low,
  input wire logic oscillator_input,
  input wire logic watchdog_timeout,
  input wire logic sleeping,
  input wire logic int_wake,
  input wire logic [31:0] pc_current,
  output logic core_reset_n,
  output logic registers_reset_n,
  output logic [31:0] pc_load,
  output logic external_reset_pin_oe
);

  // ==========================================================
  // input synchronisers
  logic [1:0] pin_s_r;
  logic [1:0] bor_s_r;
  logic [2:0] osc_s_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_s_r <= 2'h3;
      bor_s_r <= 2'h0;
      osc_s_r <= 3'h0;
    end
    else
    begin
      pin_s_r <= {pin_s_r[0], external_reset_pin_n};
      bor_s_r <= {bor_s_r[0], supply_low};
      osc_s_r <= {osc_s_r[1:0], oscillator_input};
    end
  end
  wire logic pin_low = !pin_s_r[1];
  wire logic osc_rise = osc_s_r[1] && !osc_s_r[2];

  // ==========================================================
  // registers
  logic [7:0] status_r;
  logic [1:0] power_control_register_r;
  logic [3:0] cfg_r;
  logic [2:0] cause_r;
  logic [31:0] prdata_r;
  wire logic powerup_timer_en = cfg_r[RTS_CFG_POWERUP_TIMER_EN];
  wire logic bor_en = cfg_r[RTS_CFG_BOR_EN];
  wire rts_osc_t mode = rts_osc_t'(cfg_r[RTS_CFG_MODE_LO +: 2]);
  wire logic xtal = (mode != RTS_RC);

  // ==========================================================
  // pin glitch filter
  logic [7:0] filt_cnt_r;
  logic pin_rst_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      filt_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end
    else if (!pin_low)
    begin
      filt_cnt_r <= 8'h00;
      pin_rst_r <= 1'b0;
    end
    else if (filt_cnt_r < 8'(FILT_CYC)) // short pulses ignored
      filt_cnt_r <= filt_cnt_r + 8'h01;
    else
      pin_rst_r <= 1'b1;
  end

  // ==========================================================
  // brown-out qualifier
  logic [7:0] bor_cnt_r;
  logic bor_act_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bor_cnt_r <= 8'h00;
      bor_act_r <= 1'b0;
    end
    else if (!bor_s_r[1] || !bor_en) // disabled: no reset
    begin
      bor_cnt_r <= 8'h00;
      bor_act_r <= 1'b0;
    end
    else if (bor_cnt_r < 8'(BOR_CYC)) // min low time
      bor_cnt_r <= bor_cnt_r + 8'h01;
    else
      bor_act_r <= 1'b1;
  end
  wire logic bor_hold = bor_act_r && bor_s_r[1];

  // ==========================================================
  // sequencer state machine
  typedef enum logic [2:0] {
    RTS_S_POR, RTS_S_HOLD, RTS_S_POWERUP_TIMER, RTS_S_OST, RTS_S_RUN
  } rts_state_t;
  rts_state_t state_r;
  logic [31:0] tmr_r;
  logic por_seq_r;
  logic wdt_d_r;
  wire logic wdt_rise = watchdog_timeout && !wdt_d_r;
  wire logic powerup_timer_on = powerup_timer_en || bor_en;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_r <= RTS_S_POR;
      tmr_r <= 32'h0;
      por_seq_r <= 1'b1;
      wdt_d_r <= 1'b0;
    end
    else
    begin
      wdt_d_r <= watchdog_timeout;
      case (state_r)
        RTS_S_POR:
        begin
          tmr_r <= 32'h0;
          state_r <= powerup_timer_on ? RTS_S_POWERUP_TIMER : RTS_S_OST;
        end
        RTS_S_HOLD:
        begin
          tmr_r <= 32'h0;
          if (!bor_hold) // stay down while supply low
            state_r <= RTS_S_POWERUP_TIMER;
        end
        RTS_S_POWERUP_TIMER:
        begin
          if (bor_hold) // restart timer
            state_r <= RTS_S_HOLD;
          else if (tmr_r >= 32'(POWERUP_TIMER_CYC - 1))
          begin
            tmr_r <= 32'h0;
            state_r <= RTS_S_OST;
          end
          else
            tmr_r <= tmr_r + 32'h1;
        end
        RTS_S_OST:
        begin
          if (bor_hold)
            state_r <= RTS_S_HOLD;
          else if (!xtal || !por_seq_r) // none in rc
            state_r <= RTS_S_RUN;
          else if (tmr_r >= 32'(OST_CNT))
            state_r <= RTS_S_RUN;
          else if (osc_rise)
            tmr_r <= tmr_r + 32'h1;
        end
        RTS_S_RUN:
        begin
          tmr_r <= 32'h0;
          por_seq_r <= 1'b0;
          if (bor_hold)
            state_r <= RTS_S_HOLD;
          else if (sleeping && wdt_rise && xtal)
          begin
            por_seq_r <= 1'b1; // wake needs oscillator start
            state_r <= RTS_S_OST;
          end
        end
        default:
          state_r <= RTS_S_POR;
      endcase
    end
  end

  // ==========================================================
  // reset kind detection and flags
  rts_kind_t kind;
  always_comb
  begin
    kind = RTS_K_NONE;
    if (bor_hold && state_r != RTS_S_HOLD)
      kind = RTS_K_BOR;
    else if (pin_rst_r && !sleeping && core_reset_n)
      kind = RTS_K_PIN_RUN;
    else if (pin_rst_r && sleeping && core_reset_n)
      kind = RTS_K_PIN_SLP;
    else if (wdt_rise && !sleeping)
      kind = RTS_K_WDT_RUN;
    else if (wdt_rise && sleeping)
      kind = RTS_K_WDT_WAKE;
    else if (int_wake && sleeping)
      kind = RTS_K_INT_WAKE;
  end

  logic wdt_hold_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      status_r <= 8'h18; // por: timeout and power-down set
      power_control_register_r <= 2'h0; // por flag 0
      cause_r <= 3'(RTS_K_POR);
      cfg_r <= 4'h1;
      pc_load <= RTS_PC_RESET;
      wdt_hold_r <= 1'b0;
    end
    else
    begin
      wdt_hold_r <= 1'b0;
      if (kind != RTS_K_NONE)
        cause_r <= 3'(kind);
      case (kind)
        RTS_K_BOR:
        begin
          status_r[RTS_TO_BIT] <= 1'b1;
          status_r[RTS_PD_BIT] <= 1'b1;
          power_control_register_r[RTS_BOR_BIT] <= 1'b0;
          pc_load <= RTS_PC_RESET;
        end
        RTS_K_PIN_RUN:
          pc_load <= RTS_PC_RESET;
        RTS_K_PIN_SLP:
        begin
          status_r[RTS_TO_BIT] <= 1'b1;
          status_r[RTS_PD_BIT] <= 1'b0;
          pc_load <= RTS_PC_RESET;
        end
        RTS_K_WDT_RUN:
        begin
          status_r[RTS_TO_BIT] <= 1'b0;
          status_r[RTS_PD_BIT] <= 1'b1;
          pc_load <= RTS_PC_RESET;
          wdt_hold_r <= 1'b1;
        end
        RTS_K_WDT_WAKE:
        begin
          status_r[RTS_TO_BIT] <= 1'b0;
          status_r[RTS_PD_BIT] <= 1'b0;
          pc_load <= pc_current + 32'h1;
        end
        RTS_K_INT_WAKE:
        begin
          status_r[RTS_TO_BIT] <= 1'b1;
          status_r[RTS_PD_BIT] <= 1'b0;
          pc_load <= pc_current + 32'h1;
        end
        default:
        begin
          // software writes; TO and PD kept, por and bor flags both writable
          if (psel && penable && pwrite && paddr == RTS_STATUS_OFF)
            status_r <= {status_r[7:5], status_r[4:3], pwdata[2:0]};
          if (psel && penable && pwrite && paddr == RTS_POWER_CONTROL_REGISTER_OFF)
            power_control_register_r <= pwdata[1:0];
          if (psel && penable && pwrite && paddr == RTS_CFG_OFF)
            cfg_r <= pwdata[3:0];
        end
      endcase
    end
  end

  // ==========================================================
  // reset outputs, registered so release is synchronous
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      core_reset_n <= 1'b0;
      registers_reset_n <= 1'b0;
      external_reset_pin_oe <= 1'b0;
    end
    else
    begin
      // all sources merged pin release is immediate
      core_reset_n <= (state_r == RTS_S_RUN) && !pin_rst_r &&
        !bor_hold && !wdt_hold_r;
      // watchdog wake spares registers
      registers_reset_n <= !(kind == RTS_K_BOR || kind == RTS_K_PIN_RUN ||
        kind == RTS_K_PIN_SLP || kind == RTS_K_WDT_RUN ||
        state_r == RTS_S_POR);
      external_reset_pin_oe <= 1'b0; // never drive the pin
    end
  end

  // ==========================================================
  // apb read port, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == RTS_STATUS_OFF ||
        paddr == RTS_POWER_CONTROL_REGISTER_OFF || paddr == RTS_CFG_OFF ||
        paddr == RTS_CAUSE_OFF || paddr == RTS_WAKE_OFF);
      case (paddr)
        RTS_STATUS_OFF: prdata <= {24'h0, status_r};
        RTS_POWER_CONTROL_REGISTER_OFF: prdata <= {30'h0, power_control_register_r};
        RTS_CFG_OFF: prdata <= {28'h0, cfg_r};
        RTS_CAUSE_OFF: prdata <= {29'h0, cause_r};
        RTS_WAKE_OFF: prdata <= pc_load;
        default: prdata <= 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

// File: rts_pkg.sv
// rts_pkg: constants for the reset timeout sequencer
// assumes a 100 MHz pclk and an APB register port
package rts_pkg;
  // register byte offsets
  localparam logic [7:0] RTS_STATUS_OFF = 8'h00;
  localparam logic [7:0] RTS_POWER_CONTROL_REGISTER_OFF = 8'h04;
  localparam logic [7:0] RTS_CFG_OFF = 8'h08;
  localparam logic [7:0] RTS_CAUSE_OFF = 8'h0c;
  localparam logic [7:0] RTS_WAKE_OFF = 8'h10;
  // status flag bit positions
  localparam int RTS_TO_BIT = 4;
  localparam int RTS_PD_BIT = 3;
  // power control bits
  localparam int RTS_POR_BIT = 1;
  localparam int RTS_BOR_BIT = 0;
  // config bits
  localparam int RTS_CFG_POWERUP_TIMER_EN = 0;
  localparam int RTS_CFG_BOR_EN = 1;
  localparam int RTS_CFG_MODE_LO = 2;
  // timing
  localparam int RTS_POWERUP_TIMER_MS = 72;
  localparam int RTS_CLK_MHZ = 100;
  localparam int RTS_POWERUP_TIMER_CYC = RTS_POWERUP_TIMER_MS * 1000 * RTS_CLK_MHZ;
  localparam int RTS_OST_CNT = 1024;
  localparam int RTS_FILT_CYC = 4;
  localparam int RTS_BOR_CYC = 4;
  localparam logic [31:0] RTS_PC_RESET = 32'h0000_0000;
  // oscillator modes
  typedef enum logic [1:0] {
    RTS_LP, RTS_XT, RTS_HS, RTS_RC
  } rts_osc_t;
  // reset kinds
  typedef enum logic [2:0] {
    RTS_K_NONE, RTS_K_POR, RTS_K_PIN_RUN, RTS_K_PIN_SLP,
    RTS_K_WDT_RUN, RTS_K_WDT_WAKE, RTS_K_BOR, RTS_K_INT_WAKE
  } rts_kind_t;
endpackage

// File: rts_sequencer_asserts.sv
// rts_sequencer_asserts: port checks for the reset sequencer
// assumes binding onto rts_sequencer, zero-wait apb slave
`timescale 1ns/10ps
`default_nettype none
// ====================
// checker
module rts_sequencer_asserts
  import rts_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_timeout,
  input wire logic sleeping,
  input wire logic core_reset_n,
  input wire logic registers_reset_n,
  input wire logic external_reset_pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // apb answer timing
  ready_in_access_a: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  err_with_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  unmapped_err_a: assert property
    (pready && paddr > 8'h10 |-> pslverr && prdata == 32'h0)
    else $error("unmapped access accepted");
  // reset sequencing
  pin_never_driven_a: assert property (!external_reset_pin_oe)
    else $error("reset pin driven");
  por_hold_a: assert property ($rose(presetn) |-> !core_reset_n[*8])
    else $error("core left reset early");
  pin_hold_a: assert property
    (!external_reset_pin_n[*8] |=> !core_reset_n)
    else $error("held pin gave no reset");
  wdt_run_a: assert property
    ($rose(watchdog_timeout) && !sleeping && core_reset_n
     |-> ##[1:8] !registers_reset_n)
    else $error("watchdog reset missed");
  wdt_wake_a: assert property
    ($rose(watchdog_timeout) && sleeping && core_reset_n
     |-> registers_reset_n[*8])
    else $error("wake reset registers");
endmodule
bind rts_sequencer rts_sequencer_asserts rts_sequencer_asserts_inst (
  .pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
  .external_reset_pin_n, .watchdog_timeout, .sleeping, .core_reset_n,
  .registers_reset_n, .external_reset_pin_oe
);
`default_nettype wire

// File: rts_partner.sv
// rts_partner: reset pin, supply monitor and crystal model
// assumes pclk from the bench; oscillator runs free
`timescale 1ns/10ps
`default_nettype none
// ====================
// far side model
module rts_partner
(
  input wire logic pclk,
  output logic pin_n,
  output logic sup_low,
  output logic osc
);
  // free crystal, phase unrelated to pclk
  initial
  begin
    pin_n = 1'b1;
    sup_low = 1'b0;
    osc = 1'b0;
    forever #13 osc = ~osc;
  end
  // pin held low for n cycles
  task automatic pin_low(input int n);
    pin_n <= 1'b0;
    repeat (n) @(posedge pclk);
    pin_n <= 1'b1;
    @(posedge pclk);
  endtask
  // supply below threshold for n cycles
  task automatic dip(input int n);
    sup_low <= 1'b1;
    repeat (n) @(posedge pclk);
    sup_low <= 1'b0;
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// File: test_rts_sequencer.sv
// test_rts_sequencer: directed tests of the reset sequencer
// assumes rts_partner drives pin, supply and oscillator
`timescale 1ns/10ps
`default_nettype none
// ====================
// testbench
module test_rts_sequencer;
  import rts_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, wdt, slp, seen, iwk, pin_oe;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pcur, pc_load;
  logic pready, pslverr, core_n, regs_n, pin_n, sup_low, osc;
  int miscompares = 0;
  int cmp_count = 0;
  rts_partner rts_partner_inst (.pclk(pclk), .pin_n(pin_n),
    .sup_low(sup_low), .osc(osc));
  rts_sequencer #(.POWERUP_TIMER_CYC(20), .OST_CNT(8)) rts_sequencer_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .external_reset_pin_n(pin_n),
    .supply_low(sup_low), .oscillator_input(osc), .watchdog_timeout(wdt),
    .sleeping(slp), .int_wake(iwk), .pc_current(pcur),
    .core_reset_n(core_n), .registers_reset_n(regs_n),
    .pc_load(pc_load), .external_reset_pin_oe(pin_oe));
  // clock and register-reset monitor
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  always @(posedge pclk)
    if (regs_n !== 1'b1) seen <= 1'b1;
  task automatic finish_test;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // one apb transfer, waits for pready
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int i;
    i = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 50);
    if (i >= 50) chk(32'h0, 32'h1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  // cycles until core leaves reset
  task automatic wait_rel(output int n);
    n = 0;
    while (core_n !== 1'b0 && n < 40) @(posedge pclk) n++;
    n = 0;
    while (core_n !== 1'b1 && n < 3000) @(posedge pclk) n++;
  endtask
  task automatic t_por;
    logic [31:0] q;
    logic e;
    int n;
    wait_rel(n);
    chk({31'h0, n >= 28}, 32'h1);
    rd(RTS_STATUS_OFF, 32'h18);
    rd(RTS_POWER_CONTROL_REGISTER_OFF, 32'h0);
    rd(RTS_CFG_OFF, 32'h1);
    rd(RTS_CAUSE_OFF, 32'(RTS_K_POR));
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk(q, 32'h0);
    chk({31'h0, e}, 32'h1);
    chk({31'h0, pin_oe}, 32'h0);
    wr(RTS_STATUS_OFF, 32'h5);
    rd(RTS_STATUS_OFF, 32'h1d);
  endtask
  task automatic t_wdt(input logic s);
    int n;
    slp <= s;
    pcur <= 32'h100;
    seen <= 1'b0;
    @(posedge pclk);
    wdt <= 1'b1;
    @(posedge pclk);
    wdt <= 1'b0;
    wait_rel(n);
    slp <= 1'b0;
    chk(seen, s ? 1'b0 : 1'b1);
    rd(RTS_STATUS_OFF, s ? 32'h05 : 32'h0d);
    rd(RTS_CAUSE_OFF, s ? 32'(RTS_K_WDT_WAKE) : 32'(RTS_K_WDT_RUN));
    rd(RTS_WAKE_OFF, s ? 32'h101 : 32'h0);
  endtask
  task automatic t_pin;
    int n;
    slp <= 1'b1;
    rts_partner_inst.pin_low(10);
    wait_rel(n);
    slp <= 1'b0;
    rd(RTS_STATUS_OFF, 32'h15);
    rd(RTS_CAUSE_OFF, 32'(RTS_K_PIN_SLP));
    rts_partner_inst.pin_low(1);
    repeat (10) @(posedge pclk);
    chk(core_n, 1'b1);
    rts_partner_inst.pin_low(10);
    wait_rel(n);
    rd(RTS_STATUS_OFF, 32'h15);
    rd(RTS_CAUSE_OFF, 32'(RTS_K_PIN_RUN));
  endtask
  task automatic t_bor;
    int n;
    wr(RTS_POWER_CONTROL_REGISTER_OFF, 32'h3);
    wr(RTS_CFG_OFF, 32'h0e);
    rts_partner_inst.dip(10);
    repeat (10) @(posedge pclk);
    rts_partner_inst.dip(10);
    wait_rel(n);
    chk({31'h0, n >= 20}, 32'h1);
    rd(RTS_POWER_CONTROL_REGISTER_OFF, 32'h2);
    rd(RTS_STATUS_OFF, 32'h1d);
    rd(RTS_CAUSE_OFF, 32'(RTS_K_BOR));
    wr(RTS_CFG_OFF, 32'h0c);
    rts_partner_inst.dip(10);
    repeat (20) @(posedge pclk);
    chk(core_n, 1'b1);
    rts_partner_inst.pin_low(10);
    wait_rel(n);
    chk({31'h0, n < 10}, 32'h1);
  endtask
  // interrupt wake from sleep: flags and resume address
  task automatic t_int;
    slp <= 1'b1;
    pcur <= 32'h200;
    iwk <= 1'b1;
    @(posedge pclk);
    @(posedge pclk);
    iwk <= 1'b0;
    slp <= 1'b0;
    @(posedge pclk);
    chk({31'h0, core_n}, 32'h1);
    rd(RTS_STATUS_OFF, 32'h15);
    rd(RTS_CAUSE_OFF, 32'(RTS_K_INT_WAKE));
    rd(RTS_WAKE_OFF, 32'h201);
    chk({31'h0, pin_oe}, 32'h0);
  endtask
  // watchdog against hangs
  initial
  begin
    #500000;
    miscompares++;
    finish_test();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, wdt, slp, seen, iwk} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    pcur = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_por();
    t_wdt(1'b0);
    t_wdt(1'b1);
    t_pin();
    t_bor();
    t_int();
    finish_test();
  end
endmodule
`default_nettype wire
